/* File: core/pira_reg_access.v */
// Register access handler between the process image and the user registers.
// Assumes request bytes are synchronous to clk_i; reset marks a terminal restart.
//
// Function
// - Register access happens only while the request byte access bit is set.
// - The write bit selects read when clear and write when set.
// - The low six request bits give the register index.
// - A read receipt equals the request byte exactly.
// - A write receipt equals the request byte with the write bit cleared.
// - A read returns the addressed register, high byte then low byte.
// - The output data word is ignored during a read.
// - Byte 0 is control or status, bytes 1 and 2 the data word.
// - User registers reject writes; register 31 always accepts writes.
// - Writing 0x1235 to register 31 lifts write protection.
// - Writing any other value to register 31 restores protection.
// - Register 32 changes affect terminal behaviour only after the next restart; register 31 acts at once.
// - Register 32 holds the options word and reads back after a permitted write.
// - Register 9 returns the firmware version as two ASCII characters.
// - The code word clears on restart.
// - Permitted writes to register 32 are kept in storage that survives restart; the register 31 code word does not survive it.
`timescale 1ns/1ns
`include "pira_consts.vh"

module pira_reg_access (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_b_i,
    // Process image from the controller
    input  wire [7:0]  request_byte_i,
    input  wire [7:0]  output_data_word_hi_i,
    input  wire [7:0]  output_data_word_lo_i,
    // Process image to the controller
    output reg  [7:0]  receipt_byte_o,
    output reg  [7:0]  input_data_word_hi_o,
    output reg  [7:0]  input_data_word_lo_o,
    // Options in effect since restart, and the current protection state
    output reg  [15:0] terminal_options_o,
    output reg         write_unlocked_o
);
    // Decoded request fields.
    reg         access;
    reg         is_write;
    reg         is_read;
    reg  [5:0]  idx;
    reg  [15:0] wdata;
    // Register hits and write strobes for the request in hand.
    reg         hit_fw_ver;
    reg         hit_unlock;
    reg         hit_options;
    reg         unlock_wr;
    reg         opt_wr;
    // Next values of the answer and of the code word.
    reg  [7:0]  receipt_d;
    reg  [15:0] rdata_d;
    reg  [15:0] data_word_d;
    reg  [15:0] write_unlock_word_d;
    // Code word register and the protection state it implies.
    reg  [15:0] write_unlock_word_q;
    reg         unlocked;
    // Options word as stored and as in effect since the last restart.
    wire [15:0] options_stored;
    wire [15:0] options_active;

    always @* begin
        wdata = {output_data_word_hi_i, output_data_word_lo_i};
    end

    always @* begin
        access = request_byte_i[`PIRA_BIT_ACCESS];
    end

    always @* begin
        is_write = access & request_byte_i[`PIRA_BIT_WRITE];
    end

    always @* begin
        is_read = access & ~request_byte_i[`PIRA_BIT_WRITE];
    end

    always @* begin
        idx = request_byte_i[`PIRA_IDX_MSB:0];
    end

    always @* begin
        hit_fw_ver = (idx == `PIRA_IDX_FW_VER);
    end

    always @* begin
        hit_unlock = (idx == `PIRA_IDX_UNLOCK);
    end

    always @* begin
        hit_options = (idx == `PIRA_IDX_OPTIONS);
    end

    always @* begin
        unlocked = (write_unlock_word_q == `PIRA_UNLOCK_CODE);
    end

    always @* begin
        unlock_wr = is_write & hit_unlock;
    end

    // protected user write
    // Every index except 31 and 32 is read-only here, so a write to it changes nothing at all.
    always @* begin
        opt_wr = is_write & hit_options & unlocked;
    end

    always @* begin
        write_unlock_word_d = write_unlock_word_q;
        if (unlock_wr) begin
            write_unlock_word_d = wdata;
        end
    end

    // nonvolatile options store
    // The store keeps its word through a restart; only the copy in effect is reloaded.
    pira_nv_store u_options (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .wr_i     (opt_wr),
        .wdata_i  (wdata),
        .stored_o (options_stored),
        .active_o (options_active)
    );

    // read mux
    // Reserved indices read as zero rather than whatever was last on the port.
    always @* begin
        rdata_d = 16'h0000;
        if (hit_fw_ver) begin
            rdata_d = `PIRA_FW_VERSION;
        end else if (hit_unlock) begin
            rdata_d = write_unlock_word_q;
        end else if (hit_options) begin
            rdata_d = options_stored;
        end
    end

    // A held request yields the same receipt again, so repeats are harmless.
    always @* begin
        receipt_d = 8'h00;
        if (is_write) begin
            receipt_d = request_byte_i & 8'hbf;
        end else if (is_read) begin
            receipt_d = request_byte_i;
        end
    end

    // After a write the old data stays on the port; the controller must ignore it.
    always @* begin
        data_word_d = {input_data_word_hi_o, input_data_word_lo_o};
        if (is_read) begin
            data_word_d = rdata_d;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            write_unlock_word_q <= `PIRA_UNLOCK_RST;
        end else begin
            write_unlock_word_q <= write_unlock_word_d;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            receipt_byte_o <= 8'h00;
        end else begin
            receipt_byte_o <= receipt_d;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            input_data_word_hi_o <= 8'h00;
            input_data_word_lo_o <= 8'h00;
        end else begin
            input_data_word_hi_o <= data_word_d[15:8];
            input_data_word_lo_o <= data_word_d[7:0];
        end
    end

    // restart-effective options
    // A write reaches this port only through a restart, never in the same run.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            terminal_options_o <= `PIRA_OPTIONS_RST;
        end else begin
            terminal_options_o <= options_active;
        end
    end

    // protection state output
    // Lags the code word by one cycle, since it is taken from the stored word.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            write_unlocked_o <= 1'b0;
        end else begin
            write_unlocked_o <= unlocked;
        end
    end
endmodule

/* File: common/pira_consts.vh */
// Constants for the process-image register access block.
// Included by the core files; holds definitions only.
`ifndef PIRA_CONSTS_VH
`define PIRA_CONSTS_VH

`define PIRA_BIT_ACCESS     7
`define PIRA_BIT_WRITE      6
`define PIRA_IDX_MSB        5
`define PIRA_IDX_W          6
`define PIRA_IDX_FW_VER     6'h09
`define PIRA_IDX_UNLOCK     6'h1f
`define PIRA_IDX_OPTIONS    6'h20
`define PIRA_UNLOCK_CODE    16'h1235
`define PIRA_UNLOCK_RST     16'h0000
`define PIRA_OPTIONS_RST    16'h0000
// Firmware version value is arbitrary ASCII ("0A").
`define PIRA_FW_VERSION     16'h3041
`define PIRA_NV_CNT         3'h3

`endif

/* File: core/pira_nv_store.v */
// Shadow of one nonvolatile word with a restart-effective copy.
// Assumes the surrounding logic gates write strobes with the unlock state.
`timescale 1ns/1ns
`include "pira_consts.vh"

module pira_nv_store (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_b_i,
    // Write port
    input  wire        wr_i,
    input  wire [15:0] wdata_i,
    // Stored value and the value in effect since the last restart
    output reg  [15:0] stored_o,
    output reg  [15:0] active_o
);
    reg        loaded_q;

    // Storage survives reset; only the effective copy is taken at restart.
    always @(posedge clk_i) begin
        if (wr_i) begin
            stored_o <= wdata_i;
        end
        if (!rst_b_i) begin
            loaded_q <= 1'b0;
            active_o <= `PIRA_OPTIONS_RST;
        end else begin
            if (!loaded_q) begin
                active_o <= stored_o;
            end
            loaded_q <= 1'b1;
        end
    end

    initial begin
        stored_o = `PIRA_OPTIONS_RST;
    end
endmodule

/* File: dv/pira_reg_access_sva.sv */
// Port checker for the register access block.
// Assumes one clock and a bind onto the block.
`timescale 1ns/1ns
`include "pira_consts.vh"
module pira_reg_access_sva (
    input logic        clk_i, rst_b_i, write_unlocked_o,
    input logic [7:0]  request_byte_i, output_data_word_hi_i, output_data_word_lo_i,
    input logic [7:0]  receipt_byte_o, input_data_word_hi_o, input_data_word_lo_o,
    input logic [15:0] terminal_options_o
);
    logic [2:0]  up_q;
    wire  [7:0]  rq = request_byte_i;
    wire  [15:0] wd = {output_data_word_hi_i, output_data_word_lo_i};
    wire  [15:0] rd = {input_data_word_hi_o, input_data_word_lo_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Options settle just after a restart, so only later cycles must hold still.
    always @(posedge clk_i) up_q <= !rst_b_i ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
    sequence unlock_wr; rq == 8'hdf && wd == 16'h1235; endsequence
    AST_IDLE: assert property (!rq[7] |=> receipt_byte_o == 8'h00) else $error("idle");
    AST_RD: assert property (rq[7:6] == 2'h2 |=> receipt_byte_o == $past(rq)) else $error("read");
    AST_WR: assert property (rq[7:6] == 2'h3 |=> receipt_byte_o == ($past(rq) & 8'hbf)) else $error("write");
    AST_FW: assert property (rq == 8'h89 |=> rd == `PIRA_FW_VERSION) else $error("version");
    AST_CODE: assert property (unlock_wr ##1 rq == 8'h9f |=> rd == 16'h1235) else $error("code");
    AST_UNLOCK: assert property (unlock_wr |=> ##1 write_unlocked_o) else $error("unlock");
    AST_LOCK: assert property (rq == 8'hdf && wd != 16'h1235 |=> ##1 !write_unlocked_o) else $error("lock");
    AST_OPT: assert property (up_q == 3'h7 |-> $stable(terminal_options_o)) else $error("options");
endmodule

/* File: dv/pira_ctrl_model.sv */
// Controller model driving the output process image.
// Assumes requests are sampled on the rising edge.
`timescale 1ns/1ns
module pira_ctrl_model (
    input  logic       clk_i,
    output logic [7:0] req_o, hi_o, lo_o
);
    initial {req_o, hi_o, lo_o} = 24'h00_0000;
    task automatic put(input logic [7:0] cb, input logic [15:0] wd);
        @(posedge clk_i);
        #1 {req_o, hi_o, lo_o} = {cb, wd};
        @(posedge clk_i);
    endtask
endmodule

/* File: dv/tb_top.sv */
// Bench for the register access block.
// Assumes answers come one cycle after sampling.
`timescale 1ns/1ns
`include "pira_consts.vh"
module tb_top;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, unl;
    logic [7:0]  cb, hi, lo, rb, ih, il;
    logic [15:0] opts;
    int          err_count = 0, checks = 0, cyc = 0;
    initial forever #10 clk_i = ~clk_i;
    pira_ctrl_model pira_ctrl_model_inst (.clk_i(clk_i), .req_o(cb), .hi_o(hi), .lo_o(lo));
    pira_reg_access pira_reg_access_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .request_byte_i(cb),
        .output_data_word_hi_i(hi), .output_data_word_lo_i(lo), .receipt_byte_o(rb), .input_data_word_hi_o(ih),
        .input_data_word_lo_o(il), .terminal_options_o(opts), .write_unlocked_o(unl));
    task automatic chk(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic acc(input logic [7:0] c, input logic [15:0] w, e);
        pira_ctrl_model_inst.put(c, w);
        #1 chk("receipt", {8'h00, c[7] ? c & 8'hbf : 8'h00}, {8'h00, rb});
        if (c[7:6] == 2'h2) chk("data", e, {ih, il});
    endtask
    task automatic print_verdict;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        acc(8'h89, 16'hffff, `PIRA_FW_VERSION);
        acc(8'h00, 16'h1235, 16'h0000);
        acc(8'he0, 16'h0002, 16'h0000);
        acc(8'ha0, 16'h5a5a, 16'h0000);
        acc(8'h85, 16'h0000, 16'h0000);
        acc(8'hdf, 16'h1235, 16'h0000);
        acc(8'h9f, 16'h0000, 16'h1235);
        chk("unlocked", 16'h0001, {15'h0000, unl});
        acc(8'hc9, 16'h0000, 16'h0000);
        acc(8'h89, 16'h0000, `PIRA_FW_VERSION);
        acc(8'he0, 16'h0002, 16'h0000);
        acc(8'ha0, 16'h0000, 16'h0002);
        acc(8'hdf, 16'h0000, 16'h0000);
        acc(8'he0, 16'h0007, 16'h0000);
        acc(8'ha0, 16'h0000, 16'h0002);
        chk("unlocked", 16'h0000, {15'h0000, unl});
        chk("options", 16'h0000, opts);
        acc(8'hdf, 16'h1235, 16'h0000);
        acc(8'h00, 16'h0000, 16'h0000);
        rst_b_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk("options", 16'h0002, opts);
        chk("unlocked", 16'h0000, {15'h0000, unl});
        acc(8'h9f, 16'h0000, 16'h0000);
        print_verdict();
    end
endmodule
bind pira_reg_access pira_reg_access_sva pira_reg_access_sva_inst (.clk_i, .rst_b_i, .request_byte_i,
    .output_data_word_hi_i, .output_data_word_lo_i, .receipt_byte_o, .input_data_word_hi_o,
    .input_data_word_lo_o, .terminal_options_o, .write_unlocked_o);
